//--- verilog/sdd_consts.svh
// Constants for the serial display driver: sizes, pin slots, reset values, timing
`ifndef SDD_CONSTS_SVH
`define SDD_CONSTS_SVH

// ****************************************************************
// Sizes
// ****************************************************************
`define SDD_STAGES      12
`define SDD_NPINS       4

// ****************************************************************
// Pin slots in the synchronised pin vector
// ****************************************************************
`define SDD_PIN_DATA    0
`define SDD_PIN_SCLK    1
`define SDD_PIN_XFER    2
`define SDD_PIN_GATE_N  3

// ****************************************************************
// Reset values
// ****************************************************************
`define SDD_WORD_RESET  12'h000
// Pins rest high, as an open pin would; this keeps the outputs blank
`define SDD_PINS_IDLE   4'hf

// ****************************************************************
// Timing
// ****************************************************************
`define SDD_CLK_NS      40
// Fastest serial clock that the host may apply, in kHz
`define SDD_SCLK_MAX_KHZ 4000
// Edges from a pin change to the synchronised level
`define SDD_SYNC_EDGES  4

`endif

//--- verilog/sdd_pkg.sv
// Types shared by the serial display driver modules
`include "sdd_consts.svh"

package sdd_pkg;
    typedef logic [`SDD_STAGES-1:0] sdd_word_t;
    typedef logic [`SDD_NPINS-1:0]  sdd_pins_t;
endpackage

//--- verilog/sdd_pin_if.sv
// Synchronised pin levels passed from the pin synchroniser to the driver core
`timescale 1ns/1ps

interface sdd_pin_if;
    import sdd_pkg::*;
    sdd_pins_t lvl;
    modport sync (output lvl);
    modport core (input  lvl);
endinterface

//--- verilog/sdd_pin_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`include "sdd_consts.svh"

module sdd_pin_sync (
    input  wire logic              clk_sys,
    input  wire logic              srst,
    input  wire sdd_pkg::sdd_pins_t pin_raw,
    sdd_pin_if.sync                 pins
);
    import sdd_pkg::*;

    sdd_pins_t stage1;
    sdd_pins_t stage2;
    sdd_pins_t stage3;
    sdd_pins_t agree;

    // Stage 1 feeds stage 2 only; metastability stays out of the filter
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            stage1 <= `SDD_PINS_IDLE;
            stage2 <= `SDD_PINS_IDLE;
            stage3 <= `SDD_PINS_IDLE;
        end else begin
            stage1 <= pin_raw;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    assign agree = ~(stage2 ^ stage3);

    // Each pin moves only when the last two stages agree
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            pins.lvl <= `SDD_PINS_IDLE;
        end else begin
            pins.lvl <= (stage3 & agree) | (pins.lvl & ~agree);
        end
    end
endmodule

//--- verilog/sdd_driver.sv
// Twelve-output serial-in display driver core with hold stages and output gate
//
// Behaviour
// - The twelve shift stages advance once per serial clock rising edge and hold otherwise.
// - On a shift each stage takes the one below it and stage one takes the serial input.
// - While the transfer gate is high the hold stages follow the shift stages.
// - While the transfer gate is low the hold stages keep their values.
// - Each drive output is its hold stage ANDed with the active output gate.
// - The output gate is active low and when high forces all drive outputs low.
// - With the gate low, drive output n shows hold stage n one to one.
// - The cascade output always shows the last shift stage, whatever the gates do.
// - Any input pin that is left open reads as a high level.
`timescale 1ns/1ps
`include "sdd_consts.svh"

module sdd_driver (
    input  wire logic               clk_sys,
    input  wire logic               srst,
    input  wire logic               pin_data,
    input  wire logic               pin_sclk,
    input  wire logic               pin_xfer,
    input  wire logic               pin_gate_n,
    input  wire sdd_pkg::sdd_pins_t pin_open,
    output      sdd_pkg::sdd_word_t drive_outputs,
    output      logic               cascade_out
);
    import sdd_pkg::*;

    // ****************************************************************
    // Pin capture
    // ****************************************************************
    sdd_pin_if  pins ();
    sdd_pins_t  pin_raw;
    sdd_pins_t  pin_wired;

    assign pin_wired = {pin_gate_n, pin_xfer, pin_sclk, pin_data};
    // Open pins behave as pulled high
    assign pin_raw   = pin_wired | pin_open;

    sdd_pin_sync u_sync (
        .clk_sys (clk_sys),
        .srst    (srst),
        .pin_raw (pin_raw),
        .pins    (pins.sync)
    );

    logic data_lvl;
    logic sclk_lvl;
    logic xfer_lvl;
    logic gate_n_lvl;
    logic sclk_prev;
    logic sclk_rise;

    assign data_lvl   = pins.lvl[`SDD_PIN_DATA];
    assign sclk_lvl   = pins.lvl[`SDD_PIN_SCLK];
    assign xfer_lvl   = pins.lvl[`SDD_PIN_XFER];
    assign gate_n_lvl = pins.lvl[`SDD_PIN_GATE_N];
    // Data travels the same synchroniser path, so it lines up with the edge
    assign sclk_rise  = sclk_lvl & ~sclk_prev;

    // ****************************************************************
    // Shift and hold stages
    // ****************************************************************
    sdd_word_t shift_stages;
    sdd_word_t hold_stages;
    sdd_word_t next_shift;
    sdd_word_t next_hold;
    sdd_word_t next_drive;

    assign next_shift = sclk_rise ? {shift_stages[`SDD_STAGES-2:0], data_lvl}
                                  : shift_stages;
    // Follows the shift stages in the same edge, so the gate looks transparent
    assign next_hold  = xfer_lvl ? next_shift
                                 : hold_stages;

    // Output gating, one AND per line
    genvar g;
    generate
        for (g = 0; g < `SDD_STAGES; g = g + 1) begin : g_drive
            assign next_drive[g] = next_hold[g] & ~gate_n_lvl;
        end
    endgenerate

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            sclk_prev <= 1'b1;
        end else begin
            sclk_prev <= sclk_lvl;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            shift_stages <= `SDD_WORD_RESET;
            hold_stages  <= `SDD_WORD_RESET;
        end else begin
            shift_stages <= next_shift;
            hold_stages  <= next_hold;
        end
    end

    // ****************************************************************
    // Output flops
    // ****************************************************************
    // Registered so that pins never glitch on combinational decode
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            drive_outputs <= `SDD_WORD_RESET;
            cascade_out   <= 1'b0;
        end else begin
            drive_outputs <= next_drive;
            cascade_out   <= next_shift[`SDD_STAGES-1];
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (srst);

    sequence s_rise;
        sclk_lvl && !sclk_prev;
    endsequence

    sequence s_no_rise;
        !(sclk_lvl && !sclk_prev);
    endsequence

    property p_shift_idle;
        s_no_rise |=> $stable(shift_stages);
    endproperty
    a_shift_idle: assert property (p_shift_idle)
        else $error("Shift stages moved without a serial clock edge");

    property p_shift_move;
        s_rise |=> shift_stages == {$past(shift_stages[`SDD_STAGES-2:0]), $past(data_lvl)};
    endproperty
    a_shift_move: assert property (p_shift_move)
        else $error("Shift stages did not move up by one");

    property p_hold_follow;
        xfer_lvl |=> hold_stages == shift_stages;
    endproperty
    a_hold_follow: assert property (p_hold_follow)
        else $error("Hold stages did not follow while transfer gate high");

    property p_hold_keep;
        !xfer_lvl |=> $stable(hold_stages);
    endproperty
    a_hold_keep: assert property (p_hold_keep)
        else $error("Hold stages changed while transfer gate low");

    property p_and_gate;
        ##1 drive_outputs == (hold_stages & {`SDD_STAGES{!$past(gate_n_lvl)}});
    endproperty
    a_and_gate: assert property (p_and_gate)
        else $error("Drive outputs differ from gated hold stages");

    sequence s_blank_held;
        gate_n_lvl [*2];
    endsequence

    property p_blank;
        s_blank_held |-> drive_outputs == `SDD_WORD_RESET;
    endproperty
    a_blank: assert property (p_blank)
        else $error("Drive outputs not blank while output gate high");

    property p_map;
        !gate_n_lvl ##1 (xfer_lvl && !gate_n_lvl)
            |=> drive_outputs == shift_stages && hold_stages == shift_stages;
    endproperty
    a_map: assert property (p_map)
        else $error("Drive outputs not mapped one to one");

    property p_cascade;
        s_rise ##1 1'b1 |-> cascade_out == shift_stages[`SDD_STAGES-1]
                           && cascade_out == $past(shift_stages[`SDD_STAGES-2]);
    endproperty
    a_cascade: assert property (p_cascade)
        else $error("Cascade output is not the last shift stage");

    property p_open_high;
        pin_open[`SDD_PIN_GATE_N] [*4] |=> gate_n_lvl;
    endproperty
    a_open_high: assert property (p_open_high)
        else $error("Open output gate pin did not read high");

    property p_open_data;
        pin_open[`SDD_PIN_DATA] [*4] |=> data_lvl;
    endproperty
    a_open_data: assert property (p_open_data)
        else $error("Open serial data pin did not read high");

    property p_open_sclk;
        pin_open[`SDD_PIN_SCLK] [*4] |=> sclk_lvl;
    endproperty
    a_open_sclk: assert property (p_open_sclk)
        else $error("Open serial clock pin did not read high");

    property p_open_xfer;
        pin_open[`SDD_PIN_XFER] [*4] |=> xfer_lvl;
    endproperty
    a_open_xfer: assert property (p_open_xfer)
        else $error("Open transfer gate pin did not read high");

    // Catches a cascade tap taken from the wrong stage or the hold bank
    property p_cascade_tap;
        cascade_out == shift_stages[`SDD_STAGES-1];
    endproperty
    a_cascade_tap: assert property (p_cascade_tap)
        else $error("Cascade output differs from the last shift stage");

    sequence s_gates_steady;
        !xfer_lvl && $stable(gate_n_lvl);
    endsequence

    property p_drive_frozen;
        s_gates_steady |=> $stable(drive_outputs);
    endproperty
    a_drive_frozen: assert property (p_drive_frozen)
        else $error("Drive outputs moved while the hold stages were closed");
endmodule

//--- test/sdd_host.sv
// Host controller model that drives the display driver pins
`timescale 1ns/1ps

module sdd_host (
    input  wire logic clk_sys,
    output logic      pin_data,
    output logic      pin_sclk,
    output logic      pin_xfer,
    output logic      pin_gate_n
);
    import sdd_pkg::*;

    // ****************************************************************
    // Idle levels
    // ****************************************************************
    // Outputs blank until the output gate pin is driven low
    initial begin
        pin_data   = 1'b1;
        pin_sclk   = 1'b1;
        pin_xfer   = 1'b0;
        pin_gate_n = 1'b1;
    end

    // ****************************************************************
    // Pin tasks
    // ****************************************************************
    task automatic wait_cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask

    // Half period of 4 cycles keeps the shift rate near 3 MHz
    task automatic shift_bit(input logic b);
        @(negedge clk_sys);
        pin_data = b;
        pin_sclk = 1'b0;
        wait_cyc(4);
        pin_sclk = 1'b1;
        wait_cyc(4);
        // Data is no longer held, so show a changed level
        pin_data = ~b;
    endtask

    task automatic send_word(input sdd_word_t w);
        for (int i = 11; i >= 0; i--) begin
            shift_bit(w[i]);
        end
    endtask

    task automatic set_xfer(input logic v);
        @(negedge clk_sys);
        pin_xfer = v;
    endtask

    task automatic set_gate_n(input logic v);
        @(negedge clk_sys);
        pin_gate_n = v;
    endtask
endmodule

//--- test/testbench.sv
// Self-checking bench for the serial display driver
`timescale 1ns/1ps

module testbench;
    import sdd_pkg::*;
    localparam sdd_word_t WORD_A = 12'ha53;
    localparam sdd_word_t WORD_B = 12'h3ca;
    logic      clk_sys;
    logic      srst;
    logic      pin_data;
    logic      pin_sclk;
    logic      pin_xfer;
    logic      pin_gate_n;
    sdd_pins_t pin_open;
    sdd_word_t drive_outputs;
    logic      cascade_out;
    sdd_word_t drive_outputs_chain;
    logic      cascade_out_chain;
    int        n_fail = 0;
    int        tests_run = 0;
    int        cycles = 0;

    sdd_host i_host (.clk_sys(clk_sys), .pin_data(pin_data), .pin_sclk(pin_sclk),
        .pin_xfer(pin_xfer), .pin_gate_n(pin_gate_n));

    sdd_driver i_dut (.clk_sys(clk_sys), .srst(srst), .pin_data(pin_data),
        .pin_sclk(pin_sclk), .pin_xfer(pin_xfer), .pin_gate_n(pin_gate_n),
        .pin_open(pin_open), .drive_outputs(drive_outputs), .cascade_out(cascade_out));

    // Second device on the same clock and gates, fed from the cascade output
    sdd_driver i_dut_chain (.clk_sys(clk_sys), .srst(srst),
        .pin_data(cascade_out),
        .pin_sclk(pin_sclk), .pin_xfer(pin_xfer), .pin_gate_n(pin_gate_n),
        .pin_open(pin_open), .drive_outputs(drive_outputs_chain),
        .cascade_out(cascade_out_chain));

    // ****************************************************************
    // Clock and hang guard
    // ****************************************************************
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 5000) begin
            n_fail++;
            complete_run;
        end
    end

    // ****************************************************************
    // Compare and report
    // ****************************************************************
    task automatic check_word(input string name, input sdd_word_t exp, input sdd_word_t got);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic check_bit(input string name, input logic exp, input logic got);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %b seen %b", name, exp, got);
        end
    endtask

    task automatic complete_run;
        if (n_fail == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Synchroniser delay is at most 5 cycles
    task automatic settle;
        repeat (8) @(negedge clk_sys);
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_blank_load;
        i_host.send_word(WORD_A);
        settle;
        check_word("drive_outputs", 12'h000, drive_outputs);
        check_bit("cascade_out", WORD_A[11], cascade_out);
        i_host.set_xfer(1'b1);
        settle;
        i_host.set_xfer(1'b0);
        settle;
        check_word("drive_outputs", 12'h000, drive_outputs);
        i_host.set_gate_n(1'b0);
        settle;
        check_word("drive_outputs", WORD_A, drive_outputs);
    endtask

    task automatic t_hold_shift;
        i_host.send_word(WORD_B);
        settle;
        check_word("drive_outputs", WORD_A, drive_outputs);
        check_bit("cascade_out", WORD_B[11], cascade_out);
        i_host.shift_bit(1'b1);
        settle;
        check_bit("cascade_out", WORD_B[10], cascade_out);
        i_host.set_xfer(1'b1);
        settle;
        check_word("drive_outputs", {WORD_B[10:0], 1'b1}, drive_outputs);
        i_host.set_gate_n(1'b1);
        settle;
        check_word("drive_outputs", 12'h000, drive_outputs);
        check_bit("cascade_out", WORD_B[10], cascade_out);
    endtask

    task automatic t_open_pins;
        @(negedge clk_sys);
        pin_open = 4'h9;
        i_host.set_gate_n(1'b0);
        i_host.send_word(12'h000);
        settle;
        check_word("drive_outputs", 12'h000, drive_outputs);
        @(negedge clk_sys);
        pin_open = 4'h1;
        settle;
        check_word("drive_outputs", 12'hfff, drive_outputs);
    endtask

    // Open serial clock blocks shifting; open transfer gate copies
    task automatic t_open_ctl;
        @(negedge clk_sys);
        pin_open = 4'h6;
        i_host.set_xfer(1'b0);
        i_host.send_word(12'h000);
        settle;
        check_word("drive_outputs", 12'hfff, drive_outputs);
        @(negedge clk_sys);
        pin_open = 4'h4;
        i_host.send_word(WORD_A);
        settle;
        check_word("drive_outputs", WORD_A, drive_outputs);
        @(negedge clk_sys);
        pin_open = 4'h0;
        settle;
    endtask

    // Mid-run reset, then two words pushed through both devices
    task automatic t_chain;
        @(negedge clk_sys);
        srst = 1'b1;
        repeat (3) @(negedge clk_sys);
        srst = 1'b0;
        repeat (2) @(negedge clk_sys);
        check_word("drive_outputs", 12'h000, drive_outputs);
        check_bit("cascade_out", 1'b0, cascade_out);
        i_host.send_word(WORD_B);
        i_host.send_word(WORD_A);
        settle;
        check_bit("cascade_out", WORD_A[11], cascade_out);
        check_bit("cascade_out_chain", WORD_B[11], cascade_out_chain);
        i_host.set_xfer(1'b1);
        settle;
        check_word("drive_outputs", WORD_A, drive_outputs);
        check_word("drive_outputs_chain", WORD_B, drive_outputs_chain);
    endtask

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        srst = 1'b1;
        pin_open = 4'h0;
        repeat (3) @(negedge clk_sys);
        srst = 1'b0;
        repeat (2) @(negedge clk_sys);
        check_word("drive_outputs", 12'h000, drive_outputs);
        t_blank_load;
        t_hold_shift;
        t_open_pins;
        t_open_ctl;
        t_chain;
        complete_run;
    end
endmodule
